// file: hdl/mpm_regs.svh
// constants for the motor protection monitor: limits, reset values, timing counts
// assumes a 50 MHz mclk; current settings are coded in fixed steps of rated current
`ifndef MPM_REGS_SVH
`define MPM_REGS_SVH

`define MPM_CLK_PERIOD_NS   20
`define MPM_HALF_SEC_NS     500000000
`define MPM_HALF_SEC_CYC    (`MPM_HALF_SEC_NS / `MPM_CLK_PERIOD_NS)
`define MPM_RESID_SUPPR_MS  1000
`define MPM_RESID_SUPPR_HLF (`MPM_RESID_SUPPR_MS / 500)

// limits in 1/32 of rated current
`define MPM_STEP_SHIFT      5
`define MPM_LOWER_MIN       6
`define MPM_LOWER_MAX       32
`define MPM_LOWER_DEF       6
`define MPM_UPPER_MIN       16
`define MPM_UPPER_MAX       48
`define MPM_UPPER_DEF       36
`define MPM_RESID_LIM       6
// blocking current in 1/2 of rated current
`define MPM_BLOCK_SHIFT     1
`define MPM_BLOCK_MIN       1
`define MPM_BLOCK_MAX       20
`define MPM_BLOCK_DEF       16
// blocking time in half seconds
`define MPM_BTIME_MIN       2
`define MPM_BTIME_MAX       10
`define MPM_BTIME_DEF       2
// line protection ratio 211/100
`define MPM_LINE_NUM        211
`define MPM_LINE_DEN        100
// class times in seconds
`define MPM_CLASS10_S       10
`define MPM_CLASS20_S       20
`define MPM_CLASS30_S       30

`endif

// file: hdl/mpm_pkg.sv
// types shared by the motor protection monitor and its timer
// assumes mpm_regs.svh supplies the numeric constants
package mpm_pkg;

    typedef enum logic [1:0] {SENS_OFF, SENS_SWITCH, SENS_PTC} mpm_sensor_t;
    typedef enum logic [1:0] {RESP_TRIP_HOLD, RESP_TRIP_AUTO, RESP_WARN} mpm_resp_t;
    typedef enum logic [1:0] {CLASS_10, CLASS_20, CLASS_30} mpm_class_t;
    typedef enum logic {ACT_WARN, ACT_TRIP} mpm_act_t;

endpackage

// file: hdl/mpm_tmr_if.sv
// carrier between the monitor and its half-second timers
// channel 0 times the run since switch-on, channel 1 the block duration
interface mpm_tmr_if;
    logic [1:0]       run_en;
    logic [1:0][6:0]  halfs;

    modport ctl (output run_en, input halfs);
    modport tmr (input run_en, output halfs);
endinterface

// file: hdl/mpm_timer.sv
// half-second stopwatches, one per channel, cleared while their enable is low
// assumes enables from the monitor's own flip-flops
module mpm_timer #(
    parameter int HALF_SEC_CYCLES = 25000000
) (
    // clock and reset
    input  wire logic    mclk,
    input  wire logic    rst,
    // channel enables and counts
    mpm_tmr_if.tmr       tif
);
    import mpm_pkg::*;

    localparam int CW = $clog2(HALF_SEC_CYCLES);

    typedef struct packed {
        logic [1:0][CW-1:0] cyc;
        logic [1:0][6:0]    halfs;
    } mpm_tmr_st_t;

    mpm_tmr_st_t         st_q;
    mpm_tmr_st_t         st_d;
    logic [1:0][CW-1:0]  cyc_nx;
    logic [1:0][6:0]     hlf_nx;

    for (genvar c = 0; c < 2; c++)
    begin : g_ch
        logic wrap;
        assign wrap = (st_q.cyc[c] == CW'(HALF_SEC_CYCLES - 1));
        assign cyc_nx[c] = !tif.run_en[c] ? '0 : (wrap ? '0 : st_q.cyc[c] + 1'b1);
        // saturate so a long run never wraps back under the class time
        assign hlf_nx[c] = !tif.run_en[c] ? 7'h00 :
                           (wrap && st_q.halfs[c] != 7'h7f) ? st_q.halfs[c] + 7'h01 :
                           st_q.halfs[c];
        assign tif.halfs[c] = st_q.halfs[c];
    end

    always_comb
    begin
        st_d       = st_q;
        st_d.cyc   = cyc_nx;
        st_d.halfs = hlf_nx;
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            st_q <= '0;
        else
            st_q <= st_d;
    end
endmodule

// file: hdl/mpm_monitor.sv
// motor protection monitor: winding sensor, line protection, current limits,
// blocking and residual current, trip or warn responses for sensor, limits and residual (line and block always trip), and motor enable
// assumes phase currents and rated current share one unit and are synchronous
// to mclk; sensor front-end delivers clean levels for contact, ptc and lead state
`include "mpm_regs.svh"

module mpm_monitor #(
    parameter int IW              = 16,
    parameter int HALF_SEC_CYCLES = `MPM_HALF_SEC_CYC
) (
    // clock and reset
    input  wire logic                 mclk,
    input  wire logic                 rst,
    // settings, taken on cfg_write
    input  wire logic                 cfg_write,
    input  wire mpm_pkg::mpm_sensor_t cfg_sensor,
    input  wire mpm_pkg::mpm_resp_t   cfg_sensor_resp,
    input  wire logic                 cfg_lead_mon,
    input  wire mpm_pkg::mpm_class_t  cfg_class,
    input  wire logic [5:0]           cfg_lower_limit,
    input  wire logic [5:0]           cfg_upper_limit,
    input  wire mpm_pkg::mpm_act_t    cfg_limit_act,
    input  wire logic [4:0]           cfg_block_current,
    input  wire logic [3:0]           cfg_block_time,
    input  wire mpm_pkg::mpm_act_t    cfg_resid_act,
    input  wire logic                 cfg_line_prot,
    // measurement and sensor
    input  wire logic [2:0][IW-1:0]   phase_current,
    input  wire logic [IW-1:0]        rated_operational_current,
    input  wire logic [IW-1:0]        max_setting_current,
    input  wire logic                 sensor_contact_open,
    input  wire logic                 sensor_ptc_hot,
    input  wire logic                 sensor_lead_open,
    input  wire logic                 sensor_lead_shorted,
    // commands
    input  wire logic                 start_cmd,
    input  wire logic                 trip_reset,
    // motor and signals
    output logic                      motor_on,
    output logic                      sensor_overload,
    output logic                      sensor_wire_break,
    output logic                      sensor_short,
    output logic                      overload_trip,
    output logic                      line_overload,
    output logic                      line_trip,
    output logic                      upper_violation,
    output logic                      lower_violation,
    output logic                      limit_trip,
    output logic                      residual_detected,
    output logic                      residual_trip,
    output logic                      block_detected,
    output logic                      block_trip
);
    import mpm_pkg::*;

    typedef struct packed {
        mpm_sensor_t  sensor;
        mpm_resp_t    sensor_resp;
        logic         lead_mon;
        mpm_class_t   trip_class;
        logic [5:0]   lower;
        logic [5:0]   upper;
        mpm_act_t     limit_act;
        logic [4:0]   block_cur;
        logic [3:0]   block_time;
        mpm_act_t     resid_act;
        logic         line_prot;
        logic         motor_on;
        logic         sens_ovl;
        logic         sens_brk;
        logic         sens_sht;
        logic         ovl_trip;
        logic         sens_latch;
        logic         line_ovl;
        logic         line_trip;
        logic         upper_viol;
        logic         lower_viol;
        logic         limit_trip;
        logic         resid_det;
        logic         resid_trip;
        logic         block_det;
        logic         block_trip;
    } mpm_st_t;

    mpm_st_t     st_q;
    mpm_st_t     st_d;
    mpm_tmr_if   tif ();

    // per-phase comparisons against rated current scaled by the code, residual by a fixed 6, line by max setting current
    logic [2:0]  ph_above_upper;
    logic [2:0]  ph_below_lower;
    logic [2:0]  ph_below_resid;
    logic [2:0]  ph_above_block;
    logic [2:0]  ph_above_line;

    logic [31:0] rated_w;
    logic [31:0] upper_ref;
    logic [31:0] lower_ref;
    logic [31:0] resid_ref;
    logic [31:0] block_ref;
    logic [31:0] line_ref;

    assign rated_w   = 32'(rated_operational_current);
    assign upper_ref = 32'(st_q.upper) * rated_w;
    assign lower_ref = 32'(st_q.lower) * rated_w;
    assign resid_ref = 32'(`MPM_RESID_LIM) * rated_w;
    assign block_ref = 32'(st_q.block_cur) * rated_w;
    assign line_ref  = 32'(`MPM_LINE_NUM) * 32'(max_setting_current);

    for (genvar p = 0; p < 3; p++)
    begin : g_phase
        logic [31:0] i_step;
        logic [31:0] i_half;
        logic [31:0] i_line;
        assign i_step = 32'(phase_current[p]) << `MPM_STEP_SHIFT;
        assign i_half = 32'(phase_current[p]) << `MPM_BLOCK_SHIFT;
        assign i_line = 32'(phase_current[p]) * 32'(`MPM_LINE_DEN);
        assign ph_above_upper[p] = i_step > upper_ref;
        assign ph_below_lower[p] = i_step < lower_ref;
        assign ph_below_resid[p] = i_step < resid_ref;
        assign ph_above_block[p] = i_half > block_ref;
        assign ph_above_line[p]  = i_line >= line_ref;
    end

    // run timer since switch-on, block timer while block persists
    assign tif.run_en = {st_q.block_det, st_q.motor_on};

    mpm_timer #(
        .HALF_SEC_CYCLES (HALF_SEC_CYCLES)
    ) u_timer (
        .mclk (mclk),
        .rst  (rst),
        .tif  (tif)
    );

    // out-of-range codes are clamped rather than refused
    function automatic logic [5:0] clamp6(input logic [5:0] v, input logic [5:0] lo,
                                          input logic [5:0] hi);
        clamp6 = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    logic [6:0]  class_halfs;
    logic        class_done;
    logic        resid_armed;
    logic        sens_cause;
    logic        limit_cond;
    logic        any_trip;

    always_comb
    begin
        unique case (st_q.trip_class)
            CLASS_10: class_halfs = 7'(2 * `MPM_CLASS10_S);
            CLASS_20: class_halfs = 7'(2 * `MPM_CLASS20_S);
            CLASS_30: class_halfs = 7'(2 * `MPM_CLASS30_S);
            default:  class_halfs = 7'(2 * `MPM_CLASS10_S);
        endcase
    end

    assign class_done  = st_q.motor_on && tif.halfs[0] >= class_halfs;
    assign resid_armed = st_q.motor_on && tif.halfs[0] >= 7'(`MPM_RESID_SUPPR_HLF);

    always_comb
    begin
        st_d = st_q;

        // settings
        if (cfg_write)
        begin
            st_d.sensor      = cfg_sensor;
            st_d.sensor_resp = cfg_sensor_resp;
            st_d.lead_mon    = cfg_lead_mon;
            st_d.trip_class  = cfg_class;
            st_d.lower       = clamp6(cfg_lower_limit, 6'(`MPM_LOWER_MIN),
                                      6'(`MPM_LOWER_MAX));
            st_d.upper       = clamp6(cfg_upper_limit, 6'(`MPM_UPPER_MIN),
                                      6'(`MPM_UPPER_MAX));
            st_d.limit_act   = cfg_limit_act;
            st_d.block_cur   = 5'(clamp6(6'(cfg_block_current), 6'(`MPM_BLOCK_MIN),
                                         6'(`MPM_BLOCK_MAX)));
            st_d.block_time  = 4'(clamp6(6'(cfg_block_time), 6'(`MPM_BTIME_MIN),
                                         6'(`MPM_BTIME_MAX)));
            st_d.resid_act   = cfg_resid_act;
            st_d.line_prot   = cfg_line_prot;
        end

        // winding sensor
        unique case (st_q.sensor)
            SENS_OFF:
            begin
                st_d.sens_ovl = 1'b0;
                st_d.sens_brk = 1'b0;
                st_d.sens_sht = 1'b0;
            end
            SENS_SWITCH:
            begin
                st_d.sens_ovl = sensor_contact_open;
                st_d.sens_brk = 1'b0;
                st_d.sens_sht = 1'b0;
            end
            SENS_PTC:
            begin
                st_d.sens_ovl = sensor_ptc_hot;
                st_d.sens_brk = st_q.lead_mon && sensor_lead_open;
                st_d.sens_sht = st_q.lead_mon && sensor_lead_shorted;
            end
            default:
            begin
                st_d.sens_ovl = 1'b0;
                st_d.sens_brk = 1'b0;
                st_d.sens_sht = 1'b0;
            end
        endcase
        sens_cause    = st_q.sens_ovl || st_q.sens_brk || st_q.sens_sht;
        st_d.ovl_trip = st_d.sens_ovl || st_d.sens_brk || st_d.sens_sht;

        // sensor response; setting wins over clearing in the same cycle
        if (st_q.sensor == SENS_OFF || st_q.sensor_resp == RESP_WARN)
            st_d.sens_latch = 1'b0;
        else if (sens_cause)
            st_d.sens_latch = 1'b1;
        else if (st_q.sensor_resp == RESP_TRIP_AUTO)
            st_d.sens_latch = 1'b0;
        else if (trip_reset)
            st_d.sens_latch = 1'b0;

        // line protection
        st_d.line_ovl = st_q.line_prot && st_q.motor_on && (|ph_above_line);
        if (st_q.line_ovl)
            st_d.line_trip = 1'b1;
        else if (trip_reset || !st_q.line_prot)
            st_d.line_trip = 1'b0;

        // upper and lower limits, only after class time
        st_d.upper_viol = class_done && (|ph_above_upper);
        st_d.lower_viol = class_done && (|ph_below_lower);
        limit_cond      = st_q.upper_viol || st_q.lower_viol;
        if (limit_cond && st_q.limit_act == ACT_TRIP)
            st_d.limit_trip = 1'b1;
        else if (trip_reset || st_q.limit_act == ACT_WARN)
            st_d.limit_trip = 1'b0;

        // residual current, all three phases low
        st_d.resid_det = resid_armed && (&ph_below_resid);
        if (st_q.resid_det && st_q.resid_act == ACT_TRIP)
            st_d.resid_trip = 1'b1;
        else if (trip_reset || st_q.resid_act == ACT_WARN)
            st_d.resid_trip = 1'b0;

        // block detection independent of class time
        st_d.block_det = |ph_above_block;
        if (st_q.block_det && (|ph_above_block) &&
            tif.halfs[1] >= 7'(st_q.block_time))
            st_d.block_trip = 1'b1;
        else if (trip_reset)
            st_d.block_trip = 1'b0;

        // motor runs while started and nothing holds it off
        any_trip = st_d.sens_latch || st_d.line_trip || st_d.limit_trip ||
                   st_d.resid_trip || st_d.block_trip;
        st_d.motor_on = start_cmd && !any_trip;
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            st_q             <= '0;
            st_q.sensor      <= SENS_OFF;
            st_q.sensor_resp <= RESP_TRIP_HOLD;
            st_q.lead_mon    <= 1'b1;
            st_q.trip_class  <= CLASS_10;
            st_q.lower       <= 6'(`MPM_LOWER_DEF);
            st_q.upper       <= 6'(`MPM_UPPER_DEF);
            st_q.limit_act   <= ACT_WARN;
            st_q.block_cur   <= 5'(`MPM_BLOCK_DEF);
            st_q.block_time  <= 4'(`MPM_BTIME_DEF);
            st_q.resid_act   <= ACT_TRIP;
            st_q.line_prot   <= 1'b0;
        end
        else
            st_q <= st_d;
    end

    assign motor_on          = st_q.motor_on;
    assign sensor_overload   = st_q.sens_ovl;
    assign sensor_wire_break = st_q.sens_brk;
    assign sensor_short      = st_q.sens_sht;
    assign overload_trip     = st_q.ovl_trip;
    assign line_overload     = st_q.line_ovl;
    assign line_trip         = st_q.line_trip;
    assign upper_violation   = st_q.upper_viol;
    assign lower_violation   = st_q.lower_viol;
    assign limit_trip        = st_q.limit_trip;
    assign residual_detected = st_q.resid_det;
    assign residual_trip     = st_q.resid_trip;
    assign block_detected    = st_q.block_det;
    assign block_trip        = st_q.block_trip;
endmodule

// file: testbench/mpm_motor_model.sv
// far side of the monitor: motor phase currents and winding sensor
// assumes the bench sets load and fault levels; a stopped motor draws nothing
module mpm_motor_model #(
    parameter int IW = 16
) (
    // motor state and bench controls
    input  wire logic          motor_on,
    input  wire logic [IW-1:0] load_a,
    input  wire logic [IW-1:0] load_b,
    input  wire logic          hot,
    input  wire logic          lead_open,
    input  wire logic          lead_short,
    // measured currents and sensor levels
    output logic [2:0][IW-1:0] phase_current,
    output logic               contact_open,
    output logic               ptc_hot,
    output logic               lead_broken,
    output logic               lead_shorted
);
    timeunit 1ns;
    timeprecision 1ps;
    // phase 2 may differ so a single-phase excursion can be shown
    assign phase_current[0] = motor_on ? load_a : {IW{1'b0}};
    assign phase_current[1] = motor_on ? load_a : {IW{1'b0}};
    assign phase_current[2] = motor_on ? load_b : {IW{1'b0}};
    // a hot winding opens the contact and heats the thermistor alike
    assign contact_open     = hot;
    assign ptc_hot          = hot;
    assign lead_broken      = lead_open;
    assign lead_shorted     = lead_short;
endmodule

// file: testbench/mpm_monitor_sva.sv
// assertions on the ports of the motor protection monitor
// assumes binding into mpm_monitor; time counts follow its HALF_SEC_CYCLES
module mpm_monitor_sva #(
    parameter int IW              = 16,
    parameter int HALF_SEC_CYCLES = 25000000
) (
    // clock and reset
    input wire logic                 mclk,
    input wire logic                 rst,
    // inputs watched
    input wire logic [2:0][IW-1:0]   phase_current,
    input wire logic [IW-1:0]        rated_operational_current,
    input wire logic                 sensor_lead_open,
    input wire logic                 sensor_lead_shorted,
    input wire logic                 start_cmd,
    // outputs watched
    input wire logic                 motor_on,
    input wire logic                 sensor_overload,
    input wire logic                 sensor_wire_break,
    input wire logic                 sensor_short,
    input wire logic                 overload_trip,
    input wire logic                 line_overload,
    input wire logic                 line_trip,
    input wire logic                 upper_violation,
    input wire logic                 lower_violation,
    input wire logic                 limit_trip,
    input wire logic                 residual_detected,
    input wire logic                 residual_trip,
    input wire logic                 block_detected,
    input wire logic                 block_trip
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] run_q;
    logic [31:0] blk_q;
    logic        low_all;
    assign low_all = (phase_current[0] * 32 < rated_operational_current * 6)
        && (phase_current[1] * 32 < rated_operational_current * 6)
        && (phase_current[2] * 32 < rated_operational_current * 6);
    // margins of two cycles absorb where the design starts its own timers
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            run_q <= 32'h0;
            blk_q <= 32'h0;
        end
        else
        begin
            run_q <= motor_on ? run_q + 32'h1 : 32'h0;
            blk_q <= block_detected ? blk_q + 32'h1 : 32'h0;
        end
    end
    default clocking dc @(posedge mclk);
    endclocking
    default disable iff (rst);
    a_overload_or: assert property (
        overload_trip == (sensor_overload | sensor_wire_break | sensor_short))
        else $error("overload trip differs from its causes");
    a_break_cause: assert property (
        $rose(sensor_wire_break) |-> $past(sensor_lead_open))
        else $error("wire break without open lead");
    a_short_cause: assert property (
        $rose(sensor_short) |-> $past(sensor_lead_shorted))
        else $error("short without shorted lead");
    a_start_needed: assert property ($rose(motor_on) |-> $past(start_cmd))
        else $error("motor on without start command");
    a_trip_stops: assert property (
        (line_trip || block_trip || residual_trip || limit_trip) |-> !motor_on)
        else $error("motor on while tripped");
    a_line_order: assert property ($rose(line_trip) |-> $past(line_overload))
        else $error("line trip without line overload");
    a_line_running: assert property ($rose(line_overload) |-> $past(motor_on))
        else $error("line overload with motor off");
    a_block_time: assert property ($rose(block_trip) |->
        $past(block_detected) && blk_q >= 2 * HALF_SEC_CYCLES - 2)
        else $error("block trip before blocking time");
    a_resid_wait: assert property (
        $rose(residual_detected) |-> run_q >= 2 * HALF_SEC_CYCLES - 2)
        else $error("residual seen during suppression");
    a_resid_low: assert property ($rose(residual_detected) |-> $past(low_all))
        else $error("residual with a phase above limit");
    a_limit_class: assert property (
        $rose(upper_violation || lower_violation) |-> run_q >= 20 * HALF_SEC_CYCLES - 2)
        else $error("limit violation before class time");
endmodule

bind mpm_monitor mpm_monitor_sva #(.IW(IW), .HALF_SEC_CYCLES(HALF_SEC_CYCLES)) i_sva (.*);

// file: testbench/mpm_monitor_bench.sv
// self-checking bench for the motor protection monitor
// assumes the motor model on the far side and a short half-second count
module mpm_monitor_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import mpm_pkg::*;
    logic             mclk = 1'b0;
    logic             rst = 1'b1;
    logic             cfg_write = 1'b0;
    mpm_sensor_t      sens = SENS_OFF;
    mpm_resp_t        resp = RESP_TRIP_HOLD;
    mpm_act_t         lim_act = ACT_WARN;
    mpm_class_t       cls = CLASS_10;
    mpm_act_t         res_act = ACT_TRIP;
    logic             line_en = 1'b0;
    logic             lead_mon = 1'b1;
    logic [15:0]      rated = 16'h03e8;
    logic [15:0]      load_a = 16'h03e8;
    logic [15:0]      load_b = 16'h03e8;
    logic             hot = 1'b0;
    logic             lead_open = 1'b0;
    logic             lead_short = 1'b0;
    logic             start_cmd = 1'b0;
    logic             trip_reset = 1'b0;
    logic [2:0][15:0] phase_current;
    logic             c_open, p_hot, l_open, l_short;
    logic             motor_on, s_ovl, s_brk, s_sht, ovl_trip, line_ovl, line_trip;
    logic             upper, lower, lim_trip, res_det, res_trip, blk_det, blk_trip;
    int               n_mismatch = 0;
    int               n_compared = 0;

    always #10 mclk = ~mclk;

    mpm_motor_model i_motor (.motor_on(motor_on), .load_a(load_a), .load_b(load_b),
        .hot(hot), .lead_open(lead_open), .lead_short(lead_short),
        .phase_current(phase_current), .contact_open(c_open), .ptc_hot(p_hot),
        .lead_broken(l_open), .lead_shorted(l_short));

    mpm_monitor #(.HALF_SEC_CYCLES(10)) i_dut (.mclk(mclk), .rst(rst),
        .cfg_write(cfg_write), .cfg_sensor(sens), .cfg_sensor_resp(resp),
        .cfg_lead_mon(lead_mon), .cfg_class(cls), .cfg_lower_limit(6'h06),
        .cfg_upper_limit(6'h24), .cfg_limit_act(lim_act), .cfg_block_current(5'h10),
        .cfg_block_time(4'h2), .cfg_resid_act(res_act), .cfg_line_prot(line_en),
        .phase_current(phase_current), .rated_operational_current(rated),
        .max_setting_current(rated), .sensor_contact_open(c_open), .sensor_ptc_hot(p_hot),
        .sensor_lead_open(l_open), .sensor_lead_shorted(l_short), .start_cmd(start_cmd),
        .trip_reset(trip_reset), .motor_on(motor_on), .sensor_overload(s_ovl),
        .sensor_wire_break(s_brk), .sensor_short(s_sht), .overload_trip(ovl_trip),
        .line_overload(line_ovl), .line_trip(line_trip), .upper_violation(upper),
        .lower_violation(lower), .limit_trip(lim_trip), .residual_detected(res_det),
        .residual_trip(res_trip), .block_detected(blk_det), .block_trip(blk_trip));

    task automatic tick(input int n);
        repeat (n) @(negedge mclk);
    endtask

    task automatic chk(input string what, input logic exp, input logic got);
        n_compared++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD %s expected %b seen %b", what, exp, got);
        end
    endtask

    // settings are taken at the edge with the strobe, used two cycles on
    task automatic set_cfg(input mpm_sensor_t s, input mpm_resp_t r, input mpm_act_t a,
                           input logic l);
        sens = s;
        resp = r;
        lim_act = a;
        line_en = l;
        cfg_write = 1'b1;
        tick(1);
        cfg_write = 1'b0;
        tick(2);
    endtask

    task automatic ack();
        trip_reset = 1'b1;
        tick(1);
        trip_reset = 1'b0;
        tick(3);
    endtask

    task automatic done(input string name);
        $display("test %s ended, mismatches %0d", name, n_mismatch);
    endtask

    task automatic complete_run();
        $display("compared %0d, mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        repeat (5000) @(posedge mclk);
        n_mismatch++;
        complete_run();
    end

    initial
    begin
        tick(2);
        rst = 1'b0;
        hot = 1'b1;
        start_cmd = 1'b1;
        tick(3);
        chk("motor_on", 1'b1, motor_on);
        chk("sensor_overload", 1'b0, s_ovl);
        done("sensor off");
        hot = 1'b0;
        lead_open = 1'b1;
        set_cfg(SENS_SWITCH, RESP_TRIP_HOLD, ACT_WARN, 1'b0);
        chk("sensor_wire_break", 1'b0, s_brk);
        hot = 1'b1;
        tick(3);
        chk("sensor_overload", 1'b1, s_ovl);
        chk("overload_trip", 1'b1, ovl_trip);
        chk("motor_on", 1'b0, motor_on);
        hot = 1'b0;
        lead_open = 1'b0;
        tick(3);
        chk("motor_on", 1'b0, motor_on);
        ack();
        chk("motor_on", 1'b1, motor_on);
        set_cfg(SENS_SWITCH, RESP_TRIP_AUTO, ACT_WARN, 1'b0);
        hot = 1'b1;
        tick(3);
        chk("motor_on", 1'b0, motor_on);
        hot = 1'b0;
        tick(4);
        chk("motor_on", 1'b1, motor_on);
        set_cfg(SENS_SWITCH, RESP_WARN, ACT_WARN, 1'b0);
        hot = 1'b1;
        tick(3);
        chk("overload_trip", 1'b1, ovl_trip);
        chk("motor_on", 1'b1, motor_on);
        hot = 1'b0;
        set_cfg(SENS_PTC, RESP_WARN, ACT_WARN, 1'b0);
        lead_open = 1'b1;
        tick(3);
        chk("sensor_wire_break", 1'b1, s_brk);
        lead_open = 1'b0;
        lead_short = 1'b1;
        tick(3);
        chk("sensor_short", 1'b1, s_sht);
        chk("overload_trip", 1'b1, ovl_trip);
        lead_mon = 1'b0;
        set_cfg(SENS_PTC, RESP_WARN, ACT_WARN, 1'b0);
        tick(1);
        chk("sensor_short", 1'b0, s_sht);
        lead_short = 1'b0;
        lead_mon = 1'b1;
        // class 20 so a class 10 gate would show early; residual warns first
        cls = CLASS_20;
        res_act = ACT_WARN;
        set_cfg(SENS_OFF, RESP_TRIP_HOLD, ACT_WARN, 1'b0);
        done("sensor");
        start_cmd = 1'b0;
        load_a = 16'h0064;
        load_b = 16'h0064;
        tick(2);
        start_cmd = 1'b1;
        tick(4);
        chk("residual_detected", 1'b0, res_det);
        tick(40);
        chk("residual_detected", 1'b1, res_det);
        chk("residual_trip", 1'b0, res_trip);
        chk("motor_on", 1'b1, motor_on);
        res_act = ACT_TRIP;
        set_cfg(SENS_OFF, RESP_TRIP_HOLD, ACT_WARN, 1'b0);
        chk("residual_trip", 1'b1, res_trip);
        chk("motor_on", 1'b0, motor_on);
        done("residual");
        load_a = 16'h04b0;
        load_b = 16'h04b0;
        ack();
        tick(46);
        chk("upper_violation", 1'b0, upper);
        tick(200);
        chk("upper_violation", 1'b0, upper);
        tick(200);
        chk("upper_violation", 1'b1, upper);
        chk("motor_on", 1'b1, motor_on);
        load_b = 16'h0064;
        tick(2);
        chk("lower_violation", 1'b1, lower);
        set_cfg(SENS_OFF, RESP_TRIP_HOLD, ACT_TRIP, 1'b0);
        tick(2);
        chk("limit_trip", 1'b1, lim_trip);
        chk("motor_on", 1'b0, motor_on);
        done("limits");
        set_cfg(SENS_OFF, RESP_TRIP_HOLD, ACT_WARN, 1'b0);
        load_a = 16'h03e8;
        load_b = 16'h2328;
        ack();
        chk("block_detected", 1'b1, blk_det);
        chk("motor_on", 1'b1, motor_on);
        tick(30);
        chk("block_trip", 1'b1, blk_trip);
        chk("motor_on", 1'b0, motor_on);
        done("block");
        set_cfg(SENS_OFF, RESP_TRIP_HOLD, ACT_WARN, 1'b1);
        load_b = 16'h03e8;
        ack();
        load_a = 16'h0898;
        load_b = 16'h0898;
        tick(1);
        chk("line_overload", 1'b1, line_ovl);
        tick(1);
        chk("line_trip", 1'b1, line_trip);
        chk("motor_on", 1'b0, motor_on);
        done("line");
        complete_run();
    end
endmodule
